// File: mtm_pkg.sv
// Constants shared by the modulo timer: register indices, field positions,
// reset values and source codes.
// Assumes a 32-bit AHB-Lite slave port with one register per aligned word.
package mtm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [1:0] MTM_IDX_SC  = 2'h0;
  localparam logic [1:0] MTM_IDX_CLK = 2'h1;
  localparam logic [1:0] MTM_IDX_CNT = 2'h2;
  localparam logic [1:0] MTM_IDX_MOD = 2'h3;
  localparam int         MTM_IDX_LSB = 2;
  localparam int         MTM_IDX_MSB = 3;
  localparam int         MTM_HI_LSB  = 4;

  // Status and control fields
  localparam int MTM_SC_FLAG  = 7;
  localparam int MTM_SC_IRQEN = 6;
  localparam int MTM_SC_RST   = 5;
  localparam int MTM_SC_STOP  = 4;

  // Clock configuration fields
  localparam int MTM_CLOCK_SOURCE_SELECT_MSB = 5;
  localparam int MTM_CLOCK_SOURCE_SELECT_LSB = 4;
  localparam int MTM_PS_MSB   = 3;
  localparam int MTM_PS_LSB   = 0;

  // Reset values, count step and limits
  localparam logic [7:0] MTM_CNT_RST  = 8'h00;
  localparam logic [7:0] MTM_MOD_RST  = 8'h00;
  localparam logic [7:0] MTM_CNT_MAX  = 8'hff;
  localparam logic [7:0] MTM_CNT_ONE  = 8'h01;
  localparam logic [1:0] MTM_CLOCK_SOURCE_SELECT_RST = 2'h0;
  localparam logic [3:0] MTM_PS_RST   = 4'h0;
  localparam logic [3:0] MTM_PS_MAX   = 4'h8;

  // Clock source codes
  localparam logic [1:0] MTM_SRC_BUS   = 2'h0;
  localparam logic [1:0] MTM_SRC_FIXED = 2'h1;
  localparam logic [1:0] MTM_SRC_FALL  = 2'h2;
  localparam logic [1:0] MTM_SRC_RISE  = 2'h3;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int MTM_HTRANS_ACT = 1;

  // Counter modes
  typedef enum logic [1:0] {
    MTM_MODE_STOPPED,
    MTM_MODE_FREE,
    MTM_MODE_MODULO
  } mtm_mode_t;

endpackage

// File: mtm_tick.sv
// Count clock source selector and nine-step power-of-two prescaler.
// Assumes all pin inputs are already synchronous to hclk.
module mtm_tick
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [1:0] clock_source_select,
  input  wire logic [3:0] ps,
  input  wire logic       fixed_frequency_clock,
  input  wire logic       external_timer_clock_pin,
  output logic            tick
);
  import mtm_pkg::*;

  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic       fix_prev_q;
  logic       pin_prev_q;
  logic       src_edge;
  logic [3:0] ps_eff;
  logic [7:0] mask;

  // Codes above divide-by-256 fold onto it
  assign ps_eff = (ps > MTM_PS_MAX) ? MTM_PS_MAX : ps;

  // Per bit: prescaler bit takes part in the terminal match
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_mask
      assign mask[gi] = (ps_eff > 4'(gi));
    end
  endgenerate

  // Source edge; the bus clock gives one edge every cycle
  always_comb
  begin
    case (clock_source_select)
      MTM_SRC_BUS:   src_edge = 1'b1;
      MTM_SRC_FIXED: src_edge = fixed_frequency_clock & ~fix_prev_q;
      MTM_SRC_FALL:  src_edge = ~external_timer_clock_pin & pin_prev_q;
      MTM_SRC_RISE:  src_edge = external_timer_clock_pin & ~pin_prev_q;
      default:       src_edge = 1'b0;
    endcase
  end

  // Tick when all selected prescaler bits are ones on a source edge
  assign tick = run & src_edge & ((pre_q & mask) == mask);

  // Prescaler freezes while run is low, so it resumes mid-period; restart zeroes it
  always_comb
  begin
    pre_d = pre_q;
    if (restart)
      pre_d = MTM_CNT_RST;
    else if (run & src_edge)
      pre_d = pre_q + MTM_CNT_ONE;
  end

  // Prescaler and edge history registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_q      <= MTM_CNT_RST;
      fix_prev_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pre_q      <= pre_d;
      fix_prev_q <= fixed_frequency_clock;
      pin_prev_q <= external_timer_clock_pin;
    end
  end

endmodule

// File: mtm_modulo_timer.sv
// 8-bit modulo timer with AHB-Lite register slave and overflow request.
// Assumes one AHB-Lite master, word transfers, and pins synchronous to hclk.
//
// How it works
// - Eight-bit counter, modulo, source, prescaler, interrupt
// - Stopped, free-running or modulo; stopped after reset
// - Nonzero modulo selects modulo mode, zero free-runs
// - Reset stops, zeroes count and modulo, defaults
// - Clearing the stop bit starts counting
// - Four count sources: bus, fixed, pin edges
// - Source codes: bus, fixed, pin fall, pin rise
// - Source change keeps the current count
// - Prescaler divides by one up to 256
// - Code n divides by two to n, capped
// - Prescaler change keeps the current count
// - Modulo accepts any value; zero free-runs
// - Count to modulo, then wrap to zero
// - Overflow flag sets on wrap to zero
// - Modulo write zeroes count and clears flag
// - Flag clears by read then zero write
// - Overflow between steps cancels the clear
// - Reset bit or modulo write clears flag
// - Interrupt request is flag and enable
// - Count register is read-only, reads harmless
module mtm_modulo_timer
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        fixed_frequency_clock,
  input  wire logic        external_timer_clock_pin,
  output logic             overflow_irq
);
  import mtm_pkg::*;

  // Bus phase state
  logic        ph_valid_q;
  logic        ph_valid_d;
  logic        ph_write_q;
  logic        ph_write_d;
  logic        ph_map_q;
  logic        ph_map_d;
  logic [1:0]  ph_idx_q;
  logic [1:0]  ph_idx_d;
  logic        rd_pend_q;
  logic        rd_pend_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic        addr_ok;
  logic        addr_map;
  logic        wr_now;
  logic        rd_now;
  logic [31:0] rd_mux;

  // Timer state
  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic [7:0]  mod_q;
  logic [7:0]  mod_d;
  logic [1:0]  clock_source_select_q;
  logic [1:0]  clock_source_select_d;
  logic [3:0]  ps_q;
  logic [3:0]  ps_d;
  logic        stop_q;
  logic        stop_d;
  logic        irq_en_q;
  logic        irq_en_d;
  logic        flag_q;
  logic        flag_d;
  logic        arm_q;
  logic        arm_d;
  logic        tick;
  logic        overflow;
  logic        wr_sc;
  logic        wr_clk;
  logic        wr_mod;
  logic        cnt_reset;
  logic        flag_clr;
  logic [7:0]  sc_val;
  logic [7:0]  clk_val;
  mtm_mode_t   mode;

  // Address decode; only the four low words are mapped, the rest read zero
  assign addr_ok  = hsel & hready & htrans[MTM_HTRANS_ACT];
  assign addr_map = (haddr[31:MTM_HI_LSB] == 28'h0000000) & (haddr[1:0] == 2'h0);

  // Reads take one wait state so hrdata is sampled after any prior write lands
  always_comb
  begin
    ph_valid_d = ph_valid_q;
    ph_write_d = ph_write_q;
    ph_map_d   = ph_map_q;
    ph_idx_d   = ph_idx_q;
    rd_pend_d  = 1'b0;
    if (hready)
    begin
      ph_valid_d = addr_ok;
      ph_write_d = hwrite;
      ph_map_d   = addr_map;
      ph_idx_d   = haddr[MTM_IDX_MSB:MTM_IDX_LSB];
      rd_pend_d  = addr_ok & ~hwrite;
    end
  end

  assign hreadyout = ~rd_pend_q;
  assign hresp     = 1'b0; // Always OKAY
  assign wr_now    = ph_valid_q & ph_write_q & ph_map_q;
  assign rd_now    = rd_pend_q & ph_map_q;
  assign wr_sc     = wr_now & (ph_idx_q == MTM_IDX_SC);
  assign wr_clk    = wr_now & (ph_idx_q == MTM_IDX_CLK);
  assign wr_mod    = wr_now & (ph_idx_q == MTM_IDX_MOD);

  // Readback values; reset bit always reads zero
  assign sc_val  = {flag_q, irq_en_q, 1'b0, stop_q, 4'h0};
  assign clk_val = {2'h0, clock_source_select_q, ps_q};

  always_comb
  begin
    case (ph_idx_q)
      MTM_IDX_SC:  rd_mux = {24'h000000, sc_val};
      MTM_IDX_CLK: rd_mux = {24'h000000, clk_val};
      MTM_IDX_CNT: rd_mux = {24'h000000, count_q};
      MTM_IDX_MOD: rd_mux = {24'h000000, mod_q};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // Read data register holds until the next read completes
  always_comb
  begin
    hrdata_d = hrdata_q;
    if (rd_pend_q)
      hrdata_d = rd_now ? rd_mux : 32'h00000000;
  end

  assign hrdata = hrdata_q;

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_map_q   <= 1'b0;
      ph_idx_q   <= MTM_IDX_SC;
      rd_pend_q  <= 1'b0;
      hrdata_q   <= 32'h00000000;
    end
    else
    begin
      ph_valid_q <= ph_valid_d;
      ph_write_q <= ph_write_d;
      ph_map_q   <= ph_map_d;
      ph_idx_q   <= ph_idx_d;
      rd_pend_q  <= rd_pend_d;
      hrdata_q   <= hrdata_d;
    end
  end

  // Prescaled tick source; runs only while the stop bit is clear
  mtm_tick u_tick
  (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .run                      (~stop_q),
    .restart                  (cnt_reset),
    .clock_source_select                     (clock_source_select_q),
    .ps                       (ps_q),
    .fixed_frequency_clock    (fixed_frequency_clock),
    .external_timer_clock_pin (external_timer_clock_pin),
    .tick                     (tick)
  );

  // Mode follows the stop bit and whether a modulo is loaded
  always_comb
  begin
    if (stop_q)
      mode = MTM_MODE_STOPPED;
    else if (mod_q != MTM_MOD_RST)
      mode = MTM_MODE_MODULO;
    else
      mode = MTM_MODE_FREE;
  end

  // Wrap point: modulo value, or full range in free-running mode
  always_comb
  begin
    case (mode)
      MTM_MODE_MODULO: overflow = tick & (count_q == mod_q);
      MTM_MODE_FREE:   overflow = tick & (count_q == MTM_CNT_MAX);
      MTM_MODE_STOPPED: overflow = 1'b0;
      default:         overflow = 1'b0;
    endcase
  end

  // Counter reset by the reset bit or any modulo write
  assign cnt_reset = (wr_sc & hwdata[MTM_SC_RST]) | wr_mod;

  // Counter, modulo and clock settings; clock settings changes never touch the count
  always_comb
  begin
    count_d = count_q;
    mod_d   = mod_q;
    clock_source_select_d  = clock_source_select_q;
    ps_d    = ps_q;
    if (cnt_reset)
      count_d = MTM_CNT_RST;
    else if (overflow)
      count_d = MTM_CNT_RST;
    else if (tick)
      count_d = count_q + MTM_CNT_ONE;
    if (wr_mod)
      mod_d = hwdata[7:0];
    if (wr_clk)
    begin
      clock_source_select_d = hwdata[MTM_CLOCK_SOURCE_SELECT_MSB:MTM_CLOCK_SOURCE_SELECT_LSB];
      ps_d   = hwdata[MTM_PS_MSB:MTM_PS_LSB];
    end
  end

  // Two-step clear: arm on a status read with the flag up, fire on a zero write
  assign flag_clr = cnt_reset | (wr_sc & arm_q & ~hwdata[MTM_SC_FLAG]);

  always_comb
  begin
    stop_d   = stop_q;
    irq_en_d = irq_en_q;
    flag_d   = flag_q;
    arm_d    = arm_q;
    if (wr_sc)
    begin
      stop_d   = hwdata[MTM_SC_STOP];
      irq_en_d = hwdata[MTM_SC_IRQEN];
    end
    if (flag_clr)
      flag_d = 1'b0;
    if (overflow)
      flag_d = 1'b1;
    // Any overflow or status write disarms; a fresh read must precede the clear
    if (overflow | wr_sc | wr_mod)
      arm_d = 1'b0;
    else if (rd_now & (ph_idx_q == MTM_IDX_SC) & flag_q)
      arm_d = 1'b1;
  end

  // Request stays up until the flag or the enable drops; enabling with the flag up fires at once
  assign overflow_irq = flag_q & irq_en_q;

  // Timer registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_q  <= MTM_CNT_RST;
      mod_q    <= MTM_MOD_RST;
      clock_source_select_q   <= MTM_CLOCK_SOURCE_SELECT_RST;
      ps_q     <= MTM_PS_RST;
      stop_q   <= 1'b1;
      irq_en_q <= 1'b0;
      flag_q   <= 1'b0;
      arm_q    <= 1'b0;
    end
    else
    begin
      count_q  <= count_d;
      mod_q    <= mod_d;
      clock_source_select_q   <= clock_source_select_d;
      ps_q     <= ps_d;
      stop_q   <= stop_d;
      irq_en_q <= irq_en_d;
      flag_q   <= flag_d;
      arm_q    <= arm_d;
    end
  end

endmodule

// File: mtm_modulo_timer_monitor.sv
// Checker for the timer's bus answers and overflow request.
// Assumes one master whose hready is the slave's hreadyout.
module mtm_modulo_timer_monitor
  import mtm_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        overflow_irq,
  input wire logic        fixed_frequency_clock,
  input wire logic        external_timer_clock_pin
);
  logic       acc;
  logic       wr_sc;
  logic       wr_mod;
  logic       wr_clk;
  logic       sc_dp_q;
  logic       clk_dp_q;
  logic       stop_q;
  logic       stop_d;
  logic [1:0] src_q;
  logic [1:0] src_d;
  logic       quiet;

  // Taken address phases; only SC and MOD writes may drop the request
  assign acc    = hsel & hready & htrans[MTM_HTRANS_ACT];
  assign wr_sc  = acc & hwrite & (haddr == 32'h0);
  assign wr_mod = acc & hwrite & (haddr == 32'hc);
  assign wr_clk = acc & hwrite & (haddr == 32'h4);

  // Stop bit and source as they stand next cycle; a landing write shows through
  always_comb
  begin
    stop_d = stop_q;
    src_d  = src_q;
    if (sc_dp_q)
      stop_d = hwdata[MTM_SC_STOP];
    if (clk_dp_q)
      src_d = hwdata[MTM_CLOCK_SOURCE_SELECT_MSB:MTM_CLOCK_SOURCE_SELECT_LSB];
  end

  // Write data phases and the tracked settings
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sc_dp_q  <= 1'b0;
      clk_dp_q <= 1'b0;
      stop_q   <= 1'b1;
      src_q    <= MTM_CLOCK_SOURCE_SELECT_RST;
    end
    else
    begin
      sc_dp_q  <= wr_sc;
      clk_dp_q <= wr_clk;
      stop_q   <= stop_d;
      src_q    <= src_d;
    end
  end

  // No bus-clock tick next cycle; a wrap there would legally beat the clear
  assign quiet = stop_d | (src_d != MTM_SRC_BUS);

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Read is taken, then one wait cycle, then the answer
  sequence rd_s;
    acc && !hwrite;
  endsequence
  sequence rd_end_s;
    !hreadyout ##1 hreadyout;
  endsequence
  // Clearing writes whose data phase can carry no tick at all
  sequence mod_quiet_s;
    wr_mod && quiet ##1
      $stable(fixed_frequency_clock) && $stable(external_timer_clock_pin);
  endsequence
  sequence rst_quiet_s;
    wr_sc && quiet ##1 hwdata[MTM_SC_RST] &&
      $stable(fixed_frequency_clock) && $stable(external_timer_clock_pin);
  endsequence

  read_wait_a: assert property (rd_s |=> rd_end_s)
    else $error("read wait wrong");
  write_ready_a: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  rdata_byte_a: assert property (rd_s |-> ##2 hrdata[31:8] == 24'h0)
    else $error("read upper bits set");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(acc && !hwrite, 2))
    else $error("read data moved");
  irq_reset_a: assert property ($rose(hresetn) |-> !overflow_irq)
    else $error("request after reset");
  mod_clear_a: assert property (mod_quiet_s |=> !overflow_irq)
    else $error("modulo write kept request");
  rst_clear_a: assert property (rst_quiet_s |=> !overflow_irq)
    else $error("reset bit kept request");
  irq_hold_a: assert property ($fell(overflow_irq) |-> $past(wr_sc || wr_mod, 2))
    else $error("request dropped alone");
endmodule

// File: mtm_modulo_timer_bench.sv
// Self-checking bench for the modulo timer over its AHB-Lite port.
// Assumes pins synchronous to hclk and answers within a few cycles.
module mtm_modulo_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mtm_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        fixed_frequency_clock;
  logic        pin;
  logic        irq;
  logic [31:0] rv;
  logic [1:0]  src [3];
  int          mismatches;
  int          check_count;

  mtm_modulo_timer u_mtm_modulo_timer (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fixed_frequency_clock(fixed_frequency_clock),
    .external_timer_clock_pin(pin), .overflow_irq(irq));

  // 40 MHz bus clock
  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits for hready at an edge; a stuck bus ends the run
  task automatic ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 16)
      begin
        mismatches++;
        test_done();
      end
      @(posedge hclk);
    end
  endtask

  // One single transfer; the master never pipelines
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    ready();
    rv = hrdata;
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 8'h0);
    chk(what, rv, exp);
  endtask

  // Pulses on one source; low again before the next register access
  task automatic pulse(input logic fix, input int n);
    repeat (n)
    begin
      repeat (2) @(posedge hclk);
      if (fix)
        fixed_frequency_clock <= 1'b1;
      else
        pin <= 1'b1;
      repeat (2) @(posedge hclk);
      fixed_frequency_clock <= 1'b0;
      pin <= 1'b0;
    end
    repeat (3) @(posedge hclk);
  endtask

  initial
  begin
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fixed_frequency_clock = 1'b0;
    pin = 1'b0;
    src = '{MTM_SRC_RISE, MTM_SRC_FALL, MTM_SRC_FIXED};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset state, unmapped place, count writes ignored
    rdc("sc", 8'h0, 32'h10);
    rdc("clk", 8'h4, 32'h0);
    xfer(8'h8, 1'b1, 8'h55);
    rdc("cnt", 8'h8, 32'h0);
    rdc("mod", 8'hc, 32'h0);
    rdc("gap", 8'h10, 32'h0);
    // Modulo five: count never passes it, wrap sets the flag
    xfer(8'hc, 1'b1, 8'h05);
    xfer(8'h0, 1'b1, 8'h00);
    repeat (4)
    begin
      xfer(8'h8, 1'b0, 8'h0);
      chk("bound", {31'h0, rv <= 32'h5}, 32'h1);
    end
    rdc("flag", 8'h0, 32'h80);
    // Overflow between arming read and clearing write keeps the flag
    xfer(8'hc, 1'b1, 8'h01);
    repeat (2) @(posedge hclk);
    rdc("arm", 8'h0, 32'h80);
    xfer(8'h0, 1'b1, 8'h10);
    xfer(8'h0, 1'b1, 8'h10);
    rdc("kept", 8'h0, 32'h90);
    xfer(8'h0, 1'b1, 8'h10);
    rdc("clear", 8'h0, 32'h10);
    // Request follows flag and enable; fixed source, so only pulses tick and
    // no wrap can coincide with the clearing writes below
    xfer(8'h4, 1'b1, 8'h10);
    xfer(8'h0, 1'b1, 8'h50);
    @(posedge hclk);
    chk("irq off", {31'h0, irq}, 32'h0);
    xfer(8'h0, 1'b1, 8'h40);
    pulse(1'b1, 2);
    chk("irq on", {31'h0, irq}, 32'h1);
    xfer(8'hc, 1'b1, 8'h80);
    @(posedge hclk);
    chk("irq mod", {31'h0, irq}, 32'h0);
    rdc("cnt mod", 8'h8, 32'h0);
    pulse(1'b1, 2);
    xfer(8'h0, 1'b1, 8'h70);
    rdc("cnt rst", 8'h8, 32'h0);
    rdc("mod kept", 8'hc, 32'h80);
    // Pin rise, pin fall and fixed sources in turn, switched while running
    xfer(8'h0, 1'b1, 8'h00);
    foreach (src[i])
    begin
      xfer(8'h4, 1'b1, {2'h0, src[i], 4'h0});
      pulse(src[i] == MTM_SRC_FIXED, 3);
      rdc("src", 8'h8, 32'(3 * (i + 1)));
    end
    // Top prescale code and an out-of-range code both give 256
    foreach (src[i])
    begin
      xfer(8'h0, 1'b1, 8'h30);
      xfer(8'h4, 1'b1, (i == 0) ? 8'h08 : 8'h0f);
      xfer(8'h0, 1'b1, 8'h00);
      repeat (300) @(posedge hclk);
      rdc("div", 8'h8, 32'h1);
    end
    // Modulo write zeroes the count; free run wraps at the top
    xfer(8'hc, 1'b1, 8'h00);
    xfer(8'h4, 1'b1, 8'h00);
    // Count from zero at the new rate: one tick before the read samples it
    rdc("rate", 8'h8, 32'h1);
    repeat (260) @(posedge hclk);
    rdc("wrap", 8'h0, 32'h80);
    test_done();
  end
endmodule

bind mtm_modulo_timer mtm_modulo_timer_monitor u_mtm_modulo_timer_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .overflow_irq(overflow_irq), .fixed_frequency_clock(fixed_frequency_clock),
  .external_timer_clock_pin(external_timer_clock_pin));
